//--- rtl/irq_tree_pkg.sv
// Shared constants for the interrupt aggregation tree
package irq_tree_pkg;
   // Widths
   localparam int SRC_W     = 8;
   localparam int NUM_BANKS = 9;
   localparam int GLOBAL_W  = 7;
   localparam int ADDR_W    = 8;
   localparam int DATA_W    = 32;
   localparam int SEL_W     = 4;
   localparam int CTRL_W    = 2;

   // Bank numbers of the latched status banks
   localparam int BANK_TXQ   = 0;
   localparam int BANK_TXPP  = 1;
   localparam int BANK_RXPP  = 2;
   localparam int BANK_DECAP = 3;
   localparam int BANK_ETHQ  = 4;
   localparam int BANK_BERT  = 5;
   localparam int BANK_LSYNC = 6;
   localparam int BANK_DDLY  = 7;
   localparam int BANK_OOF   = 8;

   // Register offsets (byte addresses)
   localparam logic [ADDR_W-1:0] OFS_BANK_BASE   = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_BANK_STRIDE = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_EN_DELTA    = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_GSTAT       = 8'h48;
   localparam logic [ADDR_W-1:0] OFS_GEN         = 8'h4c;
   localparam logic [ADDR_W-1:0] OFS_CTRL        = 8'h50;

   // Global status / enable bit positions
   localparam int GBIT_LI    = 0;
   localparam int GBIT_ETH   = 1;
   localparam int GBIT_BERT  = 2;
   localparam int GBIT_TRQ   = 3;
   localparam int GBIT_LSYNC = 4;
   localparam int GBIT_DDLY  = 5;
   localparam int GBIT_OOF   = 6;

   // Control register fields
   localparam int CTRL_DRIVE_BIT = 0;
   localparam int CTRL_SRST_BIT  = 1;

   // Reset values
   localparam logic [SRC_W-1:0]    RST_ENABLE = 8'h00;
   localparam logic [GLOBAL_W-1:0] RST_GEN    = 7'h00;
   localparam logic [CTRL_W-1:0]   RST_CTRL   = 2'h0;
endpackage : irq_tree_pkg

//--- rtl/status_bank.sv
// One latched status register with its enable register
`timescale 1ns/1ps
`default_nettype none
module status_bank #(
   parameter int W           = 8,
   parameter bit EN_REVERSED = 1'b0
) (
   // Clock and global reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // Source conditions
   input  wire logic [W-1:0] event_i,
   // Bus side effects
   input  wire logic [W-1:0] w1c_i,
   input  wire logic         rd_clr_i,
   input  wire logic         en_we_i,
   input  wire logic [W-1:0] en_wdata_i,
   // State
   output logic      [W-1:0] status_o,
   output logic      [W-1:0] enable_o,
   output logic              pending_o
);
   logic [W-1:0] next_status;
   logic [W-1:0] en_eff;

   if (W < 1 || W > 8) begin : g_bad_width
      $error("status_bank: width must be 1 to 8");
   end

   // Events win over any clear in the same cycle
   assign next_status = event_i
                      | (status_o & ~w1c_i & ~{W{rd_clr_i}});

   for (genvar i = 0; i < W; i++) begin : g_map
      assign en_eff[i] = EN_REVERSED ? enable_o[W-1-i] : enable_o[i];
   end

   assign pending_o = |(status_o & en_eff);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_o <= '0;
         enable_o <= '0;
      end else begin
         status_o <= next_status;
         if (en_we_i) begin
            enable_o <= en_wdata_i;
         end
      end
   end
endmodule : status_bank
`default_nettype wire

//--- rtl/irq_pin_stage.sv
// Interrupt pin driver with selectable inactive drive
`timescale 1ns/1ps
`default_nettype none
module irq_pin_stage (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Request and drive style
   input  wire logic req_i,
   input  wire logic drive_sel_i,
   // Open-drain style pin, active low
   output logic      irq_n_o,
   output logic      irq_oe_o
);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_n_o  <= 1'b1;
         irq_oe_o <= 1'b0;
      end else begin
         irq_n_o  <= ~req_i;
         irq_oe_o <= req_i | drive_sel_i;
      end
   end
endmodule : irq_pin_stage
`default_nettype wire

//--- rtl/irq_aggregation_tree.sv
// Multi-level interrupt aggregation with a Wishbone register slave
// Notes on behaviour
// - Writing one clears latched bit; zero keeps
// - Status propagates only when its enable set
// - Cleared enable still lets status latch
// - Enabled latched bits feed global status
// - Global status bits are real-time, not latched
// - Config bit selects released or driven inactive
// - No interrupt during any reset
// - Zero global enable blocks whole group
// - Reading latched register clears all bits
// - Pin deasserts once all latched cleared
// - Nine first-level source registers exposed
// - Ethernet queue enable uses reversed bits
// - Global registers optional; polling also works
`timescale 1ns/1ps
`default_nettype none
module irq_aggregation_tree #(
   parameter int W = irq_tree_pkg::SRC_W
) (
   // Clock and reset
   input  wire logic                             clk_i,
   input  wire logic                             rst_i,
   // Wishbone slave
   input  wire logic                             wb_cyc_i,
   input  wire logic                             wb_stb_i,
   input  wire logic                             wb_we_i,
   input  wire logic [irq_tree_pkg::ADDR_W-1:0]  wb_adr_i,
   input  wire logic [irq_tree_pkg::SEL_W-1:0]   wb_sel_i,
   input  wire logic [irq_tree_pkg::DATA_W-1:0]  wb_dat_i,
   output logic      [irq_tree_pkg::DATA_W-1:0]  wb_dat_o,
   output logic                                  wb_ack_o,
   // Source condition pulses or levels
   input  wire logic [W-1:0]                     tx_queue_event_i,
   input  wire logic [W-1:0]                     tx_pp_event_i,
   input  wire logic [W-1:0]                     rx_pp_event_i,
   input  wire logic [W-1:0]                     decap_event_i,
   input  wire logic [W-1:0]                     eth_queue_event_i,
   input  wire logic [W-1:0]                     bert_event_i,
   input  wire logic [W-1:0]                     link_sync_event_i,
   input  wire logic [W-1:0]                     diff_delay_event_i,
   input  wire logic [W-1:0]                     out_of_frame_event_i,
   // Interrupt pin, active low
   output logic                                  irq_n_o,
   output logic                                  irq_oe_o
);
   import irq_tree_pkg::*;

   if (W < 1 || W > 8) begin : g_bad_width
      $error("irq_aggregation_tree: W must be 1 to 8");
   end

   // Bank arrays
   logic [W-1:0]           event_arr  [NUM_BANKS];
   logic [W-1:0]           status_arr [NUM_BANKS];
   logic [W-1:0]           enable_arr [NUM_BANKS];
   logic [NUM_BANKS-1:0]   pend;
   logic [NUM_BANKS-1:0]   stat_hit;
   logic [NUM_BANKS-1:0]   en_hit;

   // Own registers
   logic [GLOBAL_W-1:0]    gen;
   logic                   drive_sel;
   logic                   soft_rst;

   // Bus decode; a pending ack masks the held strobe, so each request
   // is taken once
   wire                    acc      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire                    wr       = acc & wb_we_i & wb_sel_i[0];
   wire                    rd       = acc & ~wb_we_i;
   wire [ADDR_W-1:0]       bank_ofs = wb_adr_i - OFS_BANK_BASE;
   wire [ADDR_W-1:0]       bank_idx = bank_ofs / OFS_BANK_STRIDE;
   wire [ADDR_W-1:0]       in_bank  = bank_ofs % OFS_BANK_STRIDE;
   wire                    is_stat  = (in_bank == 8'h00);
   wire                    is_en    = (in_bank == OFS_EN_DELTA);
   wire                    bank_ok  = (bank_idx < 8'(NUM_BANKS));
   wire                    hit_gstat = (wb_adr_i == OFS_GSTAT);
   wire                    hit_gen   = (wb_adr_i == OFS_GEN);
   wire                    hit_ctrl  = (wb_adr_i == OFS_CTRL);
   wire [W-1:0]            wdat      = wb_dat_i[W-1:0];

   // Global reset: pin reset or software reset bit
   wire                    grst = rst_i | soft_rst;

   assign event_arr[BANK_TXQ]   = tx_queue_event_i;
   assign event_arr[BANK_TXPP]  = tx_pp_event_i;
   assign event_arr[BANK_RXPP]  = rx_pp_event_i;
   assign event_arr[BANK_DECAP] = decap_event_i;
   assign event_arr[BANK_ETHQ]  = eth_queue_event_i;
   assign event_arr[BANK_BERT]  = bert_event_i;
   assign event_arr[BANK_LSYNC] = link_sync_event_i;
   assign event_arr[BANK_DDLY]  = diff_delay_event_i;
   assign event_arr[BANK_OOF]   = out_of_frame_event_i;

   for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
      wire sel_b = bank_ok && (bank_idx == 8'(b));
      assign stat_hit[b] = sel_b & is_stat;
      assign en_hit[b]   = sel_b & is_en;

      // Latching, clearing and enable gating per bank
      status_bank #(
         .W           (W),
         .EN_REVERSED (b == BANK_ETHQ)
      ) u_bank (
         .clk_i      (clk_i),
         .rst_i      (grst),
         .event_i    (event_arr[b]),
         .w1c_i      ((wr & stat_hit[b]) ? wdat : '0),
         .rd_clr_i   (rd & stat_hit[b]),
         .en_we_i    (wr & en_hit[b]),
         .en_wdata_i (wdat),
         .status_o   (status_arr[b]),
         .enable_o   (enable_arr[b]),
         .pending_o  (pend[b])
      );
   end

   // Real-time global status, no storage of its own
   logic [GLOBAL_W-1:0] gstat;
   assign gstat[GBIT_LI]    = pend[BANK_TXQ] | pend[BANK_TXPP]
                            | pend[BANK_RXPP] | pend[BANK_DECAP];
   assign gstat[GBIT_ETH]   = pend[BANK_ETHQ];
   assign gstat[GBIT_BERT]  = pend[BANK_BERT];
   assign gstat[GBIT_TRQ]   = pend[BANK_TXPP] | pend[BANK_RXPP];
   assign gstat[GBIT_LSYNC] = pend[BANK_LSYNC];
   assign gstat[GBIT_DDLY]  = pend[BANK_DDLY];
   assign gstat[GBIT_OOF]   = pend[BANK_OOF];

   // Group gates, then one request; held off in reset
   wire irq_req = ~grst & |(gstat & gen);

   // Read data selection
   // An index past the last bank is masked by bank_ok below
   wire [W-1:0] bank_rd = is_en ? enable_arr[bank_idx[3:0]]
                                : status_arr[bank_idx[3:0]];
   wire [DATA_W-1:0] rd_word =
        (bank_ok && (is_stat || is_en)) ? DATA_W'(bank_rd) :
        hit_gstat ? DATA_W'(gstat) :
        hit_gen   ? DATA_W'(gen) :
        hit_ctrl  ? DATA_W'({soft_rst, drive_sel}) :
        '0;

   // Bus answer: one cycle after the request, unmapped reads zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= acc;
         wb_dat_o <= rd ? rd_word : '0;
      end
   end

   // Soft reset bit survives its own reset; only the pin or a control write clears it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         soft_rst <= RST_CTRL[CTRL_SRST_BIT];
      end else if (wr && hit_ctrl) begin
         soft_rst <= wb_dat_i[CTRL_SRST_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (grst) begin
         gen       <= RST_GEN;
         drive_sel <= RST_CTRL[CTRL_DRIVE_BIT];
      end else begin
         if (wr && hit_gen) begin
            gen <= wb_dat_i[GLOBAL_W-1:0];
         end
         if (wr && hit_ctrl) begin
            drive_sel <= wb_dat_i[CTRL_DRIVE_BIT];
         end
      end
   end

   irq_pin_stage u_pin (
      .clk_i       (clk_i),
      .rst_i       (grst),
      .req_i       (irq_req),
      .drive_sel_i (drive_sel),
      .irq_n_o     (irq_n_o),
      .irq_oe_o    (irq_oe_o)
   );

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   w1c_clear_a: assert property (
      wr && stat_hit[BANK_TXPP] && wdat[0] && !tx_pp_event_i[0] && !grst
      |=> !status_arr[BANK_TXPP][0])
      else $error("written one did not clear latched bit");

   w1c_keep_a: assert property (
      wr && stat_hit[BANK_TXPP] && !wdat[0] && status_arr[BANK_TXPP][0]
      && !grst |=> status_arr[BANK_TXPP][0])
      else $error("written zero cleared latched bit");

   enable_gate_a: assert property (
      gstat[GBIT_BERT] |-> |(status_arr[BANK_BERT] & enable_arr[BANK_BERT]))
      else $error("global bit set without enabled cause");

   masked_latch_a: assert property (
      !grst && bert_event_i[0] && !enable_arr[BANK_BERT][0]
      |=> status_arr[BANK_BERT][0])
      else $error("masked condition did not latch");

   request_pin_a: assert property (
      irq_req |=> !irq_n_o && irq_oe_o)
      else $error("request did not reach pin");

   realtime_a: assert property (
      rd && stat_hit[BANK_ETHQ] && !(|eth_queue_event_i) && !grst
      |=> !gstat[GBIT_ETH])
      else $error("global bit stayed after service");

   inactive_drive_a: assert property (
      !irq_req && !grst ##1 !grst |-> (irq_oe_o == $past(drive_sel))
      && irq_n_o)
      else $error("inactive drive style wrong");

   reset_quiet_a: assert property (
      grst |=> irq_n_o && !irq_oe_o)
      else $error("pin active during reset");

   global_block_a: assert property (
      gen == '0 |=> irq_n_o)
      else $error("interrupt passed zero global enable");

   read_clear_a: assert property (
      rd && stat_hit[BANK_TXQ] && !(|tx_queue_event_i) && !grst
      |=> status_arr[BANK_TXQ] == '0)
      else $error("read did not clear latched register");

   reorder_a: assert property (
      status_arr[BANK_ETHQ][0] && enable_arr[BANK_ETHQ][W-1]
      |-> pend[BANK_ETHQ])
      else $error("queue enable ordering wrong");

   sticky_a: assert property (
      status_arr[BANK_TXQ][0] && !(acc && stat_hit[BANK_TXQ]) && !grst
      |=> status_arr[BANK_TXQ][0])
      else $error("latched bit dropped on its own");

   ack_once_a: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");

   // Checks on the bus and pin flops, soft reset bit and bank registers
   ack_next_a: assert property (
      acc |=> wb_ack_o)
      else $error("ack not one cycle after request");

   dat_idle_a: assert property (
      !wb_ack_o |-> wb_dat_o == '0)
      else $error("read data shown outside ack");

   reset_hold_a: assert property (@(posedge clk_i) disable iff (1'b0)
      rst_i |=> irq_n_o && !irq_oe_o && !wb_ack_o)
      else $error("outputs active after reset edge");

   srst_hold_a: assert property (
      soft_rst && !(wr && hit_ctrl) |=> soft_rst)
      else $error("software reset bit cleared itself");

   bert_masked_a: assert property (
      enable_arr[BANK_BERT] == '0 && !(wr && en_hit[BANK_BERT])
      |=> !gstat[GBIT_BERT])
      else $error("masked bank reached global status");

   oof_to_pin_a: assert property (
      gstat[GBIT_OOF] && gen[GBIT_OOF] && !grst |=> !irq_n_o)
      else $error("enabled group did not drive pin");

   trq_realtime_a: assert property (
      rd && stat_hit[BANK_TXPP] && !(|tx_pp_event_i) && !pend[BANK_RXPP]
      && !(|rx_pp_event_i) && !grst |=> !gstat[GBIT_TRQ])
      else $error("queue global bit stayed after service");

   pin_cause_a: assert property (
      !irq_n_o |-> $past(|(gstat & gen)))
      else $error("pin active without enabled group");

   pin_release_a: assert property (
      !grst && (gstat & gen) == '0 |=> irq_n_o)
      else $error("pin held after causes cleared");

   ddly_read_a: assert property (
      rd && stat_hit[BANK_DDLY] && !(|diff_delay_event_i) && !grst
      |=> status_arr[BANK_DDLY] == '0)
      else $error("read left delay bits set");

   oof_clear_a: assert property (
      wr && stat_hit[BANK_OOF] && wdat == '1
      && !(|out_of_frame_event_i) && !grst |=> status_arr[BANK_OOF] == '0)
      else $error("written ones left frame bits set");

   queue_mirror_a: assert property (
      enable_arr[BANK_ETHQ] == W'(1) && !status_arr[BANK_ETHQ][W-1]
      |-> !pend[BANK_ETHQ])
      else $error("queue enable masked wrong bit");

   irq_seen_c: cover property (irq_req ##1 !irq_n_o);
   read_clear_c: cover property (rd && stat_hit[BANK_BERT]
                                 && status_arr[BANK_BERT] != '0);
   set_wins_c: cover property (wr && stat_hit[BANK_TXPP] && wdat[0]
                               && tx_pp_event_i[0]);
   soft_rst_c: cover property (soft_rst ##1 !soft_rst);
   drive_high_c: cover property (drive_sel && irq_oe_o && irq_n_o);
endmodule : irq_aggregation_tree
`default_nettype wire

//--- tb/irq_aggregation_tree_test.sv
// Self-checking bench for the interrupt aggregation tree
`timescale 1ns/1ps
`default_nettype none
module irq_aggregation_tree_test;
   import irq_tree_pkg::*;
   logic                clk_i;
   logic                rst_i;
   logic                wb_cyc_i;
   logic                wb_stb_i;
   logic                wb_we_i;
   logic [ADDR_W-1:0]   wb_adr_i;
   logic [SEL_W-1:0]    wb_sel_i;
   logic [DATA_W-1:0]   wb_dat_i;
   logic [DATA_W-1:0]   wb_dat_o;
   logic                wb_ack_o;
   logic [SRC_W-1:0]    ev [NUM_BANKS];
   logic                irq_n_o;
   logic                irq_oe_o;
   // Reference model state
   logic [SRC_W-1:0]    m_stat [NUM_BANKS];
   logic [SRC_W-1:0]    m_en [NUM_BANKS];
   logic [GLOBAL_W-1:0] m_gen;
   logic [CTRL_W-1:0]   m_ctrl;
   logic [DATA_W-1:0]   rd;
   int                  err_count;
   int                  n_checks;
   int                  cycles;
   int                  seed;
   int                  b;

   irq_aggregation_tree u_irq_aggregation_tree (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .tx_queue_event_i(ev[BANK_TXQ]),
      .tx_pp_event_i(ev[BANK_TXPP]), .rx_pp_event_i(ev[BANK_RXPP]),
      .decap_event_i(ev[BANK_DECAP]), .eth_queue_event_i(ev[BANK_ETHQ]),
      .bert_event_i(ev[BANK_BERT]), .link_sync_event_i(ev[BANK_LSYNC]),
      .diff_delay_event_i(ev[BANK_DDLY]),
      .out_of_frame_event_i(ev[BANK_OOF]),
      .irq_n_o(irq_n_o), .irq_oe_o(irq_oe_o));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // The whole run needs under two thousand cycles; this only cuts a hang
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [DATA_W-1:0] got, exp, input string what);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   function automatic logic [GLOBAL_W-1:0] gstat_m();
      logic [NUM_BANKS-1:0] p;
      logic [SRC_W-1:0]     e;
      for (int k = 0; k < NUM_BANKS; k++) begin
         e = m_en[k];
         // Ethernet queue enable masks the mirrored status position
         for (int j = 0; j < SRC_W; j++) begin
            if (k == BANK_ETHQ) e[j] = m_en[k][SRC_W-1-j];
         end
         p[k] = |(m_stat[k] & e);
      end
      return {p[BANK_OOF], p[BANK_DDLY], p[BANK_LSYNC],
              p[BANK_TXPP] | p[BANK_RXPP], p[BANK_BERT], p[BANK_ETHQ],
              |p[BANK_DECAP:BANK_TXQ]};
   endfunction : gstat_m

   task automatic model_clear();
      for (int k = 0; k < NUM_BANKS; k++) begin
         m_stat[k] = '0;
         m_en[k] = '0;
      end
      m_gen = '0;
      m_ctrl[CTRL_DRIVE_BIT] = 1'b0;
   endtask : model_clear

   task automatic wb_xfer(input logic we, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, input logic [SEL_W-1:0] s,
      output logic [DATA_W-1:0] q);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      n = 0;
      // Hold the request until ack is seen high at a rising edge
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      chk(n, 2, "ack latency");
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask : wb_xfer

   task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      logic [DATA_W-1:0] q;
      wb_xfer(1'b1, a, d, 4'hf, q);
      if (a < OFS_GSTAT && a[2]) m_en[a[6:3]] = d[SRC_W-1:0];
      else if (a < OFS_GSTAT) m_stat[a[6:3]] &= ~d[SRC_W-1:0];
      else if (a == OFS_GEN) m_gen = d[GLOBAL_W-1:0];
      else if (a == OFS_CTRL) m_ctrl = d[CTRL_W-1:0];
      if (m_ctrl[CTRL_SRST_BIT]) model_clear();
   endtask : reg_wr

   task automatic reg_chk(input logic [ADDR_W-1:0] a);
      logic [DATA_W-1:0] q;
      logic [DATA_W-1:0] e;
      e = '0;
      if (a < OFS_GSTAT) e[SRC_W-1:0] = a[2] ? m_en[a[6:3]] : m_stat[a[6:3]];
      else if (a == OFS_GSTAT) e[GLOBAL_W-1:0] = gstat_m();
      else if (a == OFS_GEN) e[GLOBAL_W-1:0] = m_gen;
      else if (a == OFS_CTRL) e[CTRL_W-1:0] = m_ctrl;
      wb_xfer(1'b0, a, '0, 4'hf, q);
      chk(q, e, "register read");
      if (a < OFS_GSTAT && !a[2]) m_stat[a[6:3]] = '0;
   endtask : reg_chk

   task automatic pulse(input int bk, input logic [SRC_W-1:0] bits);
      @(posedge clk_i);
      ev[bk] <= bits;
      @(posedge clk_i);
      ev[bk] <= '0;
      if (!m_ctrl[CTRL_SRST_BIT]) m_stat[bk] |= bits;
   endtask : pulse

   task automatic pin_chk();
      logic irq;
      repeat (3) @(negedge clk_i);
      irq = |(gstat_m() & m_gen);
      chk({30'h0, irq_n_o, irq_oe_o}, {30'h0, ~irq,
          irq | (m_ctrl[CTRL_DRIVE_BIT] & ~m_ctrl[CTRL_SRST_BIT])}, "pin");
   endtask : pin_chk

   initial begin
      seed = 19436;
      err_count = 0;
      n_checks = 0;
      rst_i = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = '0;
      wb_sel_i = '0;
      wb_dat_i = '0;
      for (int k = 0; k < NUM_BANKS; k++) ev[k] = '0;
      m_ctrl = '0;
      model_clear();
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      // Reset values, then two unmapped words past the control register
      for (int k = 0; k <= 'h58; k += 4) reg_chk(ADDR_W'(k));
      pin_chk();
      for (int i = 0; i < 60; i++) begin
         b = $unsigned($random(seed)) % NUM_BANKS;
         if (i == 30) reg_wr(OFS_CTRL, 32'h1);
         reg_wr(ADDR_W'(b * 8 + 4), $random(seed));
         reg_wr(OFS_GEN, $random(seed));
         pulse(b, SRC_W'($random(seed)));
         pin_chk();
         reg_chk(OFS_GSTAT);
         if ($random(seed) & 1) reg_wr(ADDR_W'(b * 8), $random(seed));
         else reg_chk(ADDR_W'(b * 8));
         reg_chk(ADDR_W'(b * 8));
         reg_chk(OFS_GSTAT);
         pin_chk();
      end
      // Reading every latched bank must deassert the pin, still driven inactive
      for (int k = 0; k < NUM_BANKS; k++) reg_chk(ADDR_W'(k * 8));
      pin_chk();
      reg_chk(OFS_GSTAT);
      // Soft reset blocks latching and holds the pin released
      reg_wr(OFS_GEN, 32'h7f);
      reg_wr(8'h04, 32'hff);
      pulse(0, 8'h01);
      pin_chk();
      reg_wr(OFS_CTRL, 32'h3);
      pulse(0, 8'hff);
      pin_chk();
      reg_chk(8'h00);
      reg_chk(OFS_CTRL);
      reg_wr(OFS_CTRL, 32'h0);
      // A write without the low byte lane is ignored
      wb_xfer(1'b1, OFS_GEN, 32'h7f, 4'he, rd);
      reg_chk(OFS_GEN);
      // Hardware reset in the middle of an active interrupt
      reg_wr(OFS_GEN, 32'h7f);
      reg_wr(8'h0c, 32'hff);
      pulse(BANK_TXPP, 8'h80);
      pin_chk();
      @(posedge clk_i);
      rst_i <= 1'b1;
      ev[BANK_RXPP] <= 8'hff;
      repeat (3) @(negedge clk_i);
      chk({30'h0, irq_n_o, irq_oe_o}, 32'h2, "pin during reset");
      @(posedge clk_i);
      rst_i <= 1'b0;
      ev[BANK_RXPP] <= '0;
      m_ctrl = '0;
      model_clear();
      reg_chk(8'h10);
      reg_chk(8'h08);
      end_of_test();
   end
endmodule : irq_aggregation_tree_test
`default_nettype wire
